// [hdl/tol_top.sv]
// Two-channel timer-triggered output latch with its register file.
// Assumes timer match inputs synchronous to clk and a single-cycle strobe
// register port whose read data appear in the cycle after the read strobe.
//
// Function
// - Enabled channel copies each buffer to its latch on the selected edge of its routed trigger.
// - Enabled: latched-mode pins drive latch bit, port-mode pins drive zero.
// - Disabled channel drives all six pins zero regardless of mode.
// - Each channel has 4-bit upper and lower buffers, cleared by reset.
// - Split mode: low address writes low nibble, high address writes high.
// - Reading either buffer address returns upper and lower nibbles together.
// - Wide mode: a byte write at either address updates both buffers.
// - Per-bit mode register selects latched or port mode, reset zero.
// - Control: enable bit7, edge bit6, width bit5, source bit4, rest zero.
// - Edge select zero means falling edge, one means rising edge.
// - Width zero splits channel four plus two, one makes six bits.
// - Channel zero trigger routing from timers five, four and zero.
// - Channel one trigger routing from timers eight, seven and six.
// - Two channels; upper buffer feeds pins 4-5, lower feeds pins 0-3.
// - Disabled channel: buffer write also loads the output latch.
// - Enabled channel: buffer writes never reach the latch directly.
//
// The address-and-strobe port was left to the implementer.
`timescale 1ns/100ps

module tol_top
    import tol_pkg::*;
(
    input  wire logic                               clk,
    input  wire logic                               sys_rst,
    input  wire logic [TOL_ADDR_W-1:0]              reg_addr,
    input  wire logic [TOL_DATA_W-1:0]              reg_wdata,
    input  wire logic                               reg_wr,
    input  wire logic                               reg_rd,
    output logic      [TOL_DATA_W-1:0]              reg_rdata,
    input  wire logic                               timer0_match_trigger,
    input  wire logic                               timer4_match_trigger,
    input  wire logic                               timer5_match_trigger,
    input  wire logic                               timer6_match_trigger,
    input  wire logic                               timer7_match_trigger,
    input  wire logic                               timer8_match_trigger,
    output logic      [TOL_NUM_CH-1:0][TOL_PINS-1:0] channel_output_pins
);

    // ------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------
    tol_ctrl_t                                  ctrl_reg   [TOL_NUM_CH];
    tol_ctrl_t                                  ctrl_next  [TOL_NUM_CH];
    logic      [TOL_PINS-1:0]                   mode_reg   [TOL_NUM_CH];
    logic      [TOL_PINS-1:0]                   mode_next  [TOL_NUM_CH];
    logic      [TOL_NIB_W-1:0]                  bufl_reg   [TOL_NUM_CH];
    logic      [TOL_NIB_W-1:0]                  bufl_next  [TOL_NUM_CH];
    logic      [TOL_NIB_W-1:0]                  bufh_reg   [TOL_NUM_CH];
    logic      [TOL_NIB_W-1:0]                  bufh_next  [TOL_NUM_CH];
    logic      [TOL_NIB_W-1:0]                  latl_reg   [TOL_NUM_CH];
    logic      [TOL_NIB_W-1:0]                  latl_next  [TOL_NUM_CH];
    logic      [TOL_HI_PINS-1:0]                lath_reg   [TOL_NUM_CH];
    logic      [TOL_HI_PINS-1:0]                lath_next  [TOL_NUM_CH];
    tol_fire_t                                  fire_reg   [TOL_NUM_CH];
    tol_fire_t                                  fire_next  [TOL_NUM_CH];
    logic      [TOL_NUM_CH-1:0][TOL_PINS-1:0]   pins_reg;
    logic      [TOL_NUM_CH-1:0][TOL_PINS-1:0]   pins_next;
    logic      [TOL_DATA_W-1:0]                 rdata_reg;
    logic      [TOL_DATA_W-1:0]                 rdata_next;
    logic      [TOL_NUM_CH-1:0][2:0]            trig_reg;
    logic      [TOL_NUM_CH-1:0][2:0]            trig_next;
    logic      [TOL_NUM_CH-1:0][2:0]            trig_now;

    // Per channel: a = upper split trigger, b = shared one, c = alternate.
    assign trig_now[0] = {timer5_match_trigger, timer4_match_trigger, timer0_match_trigger};
    assign trig_now[1] = {timer8_match_trigger, timer7_match_trigger, timer6_match_trigger};

    // ------------------------------------------------------------------
    // Trigger edge detection
    // ------------------------------------------------------------------
    always_comb begin
        logic [2:0] edg;
        edg = '0;
        trig_next = trig_now;
        for (int c = 0; c < TOL_NUM_CH; c++) begin
            edg = ctrl_reg[c].trigger_edge_select ? (trig_now[c] & ~trig_reg[c])
                                                  : (~trig_now[c] & trig_reg[c]);
            // source routing.
            // The edge is held one cycle so the latch moves once per edge.
            fire_next[c] = tol_route(ctrl_reg[c], edg[2], edg[1], edg[0]);
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            trig_reg <= '0;
            for (int c = 0; c < TOL_NUM_CH; c++) begin
                fire_reg[c] <= '0;
            end
        end else begin
            trig_reg <= trig_next;
            for (int c = 0; c < TOL_NUM_CH; c++) begin
                fire_reg[c] <= fire_next[c];
            end
        end
    end

    // ------------------------------------------------------------------
    // Register writes, buffers and latches
    // ------------------------------------------------------------------
    always_comb begin
        logic wr_l;
        logic wr_h;
        wr_l = 1'b0;
        wr_h = 1'b0;
        for (int c = 0; c < TOL_NUM_CH; c++) begin
            ctrl_next[c] = ctrl_reg[c];
            mode_next[c] = mode_reg[c];
            bufl_next[c] = bufl_reg[c];
            bufh_next[c] = bufh_reg[c];
            latl_next[c] = latl_reg[c];
            lath_next[c] = lath_reg[c];
            wr_l = reg_wr && (reg_addr == TOL_BUFL_ADDR[c]);
            wr_h = reg_wr && (reg_addr == TOL_BUFH_ADDR[c]);
            if (reg_wr && (reg_addr == TOL_CTRL_ADDR[c])) begin
                ctrl_next[c] = reg_wdata[TOL_EN_BIT:TOL_SRC_BIT];
            end
            if (reg_wr && (reg_addr == TOL_MODE_ADDR[c])) begin
                mode_next[c] = reg_wdata[TOL_PINS-1:0];
            end
            if (wr_l || (wr_h && ctrl_reg[c].width_mode_bit)) begin
                bufl_next[c] = reg_wdata[TOL_NIB_W-1:0];
            end
            if (wr_h || (wr_l && ctrl_reg[c].width_mode_bit)) begin
                bufh_next[c] = reg_wdata[TOL_DATA_W-1:TOL_NIB_W];
            end
            if (ctrl_reg[c].channel_enable_bit) begin
                if (fire_reg[c].lo) begin
                    latl_next[c] = bufl_reg[c];
                end
                if (fire_reg[c].hi) begin
                    lath_next[c] = bufh_reg[c][TOL_HI_PINS-1:0];
                end
            end else begin
                if (bufl_next[c] != bufl_reg[c] || wr_l || wr_h) begin
                    latl_next[c] = bufl_next[c];
                    lath_next[c] = bufh_next[c][TOL_HI_PINS-1:0];
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            for (int c = 0; c < TOL_NUM_CH; c++) begin
                ctrl_reg[c] <= TOL_CTRL_RST[TOL_EN_BIT:TOL_SRC_BIT];
                mode_reg[c] <= TOL_MODE_RST;
                bufl_reg[c] <= TOL_BUF_RST;
                bufh_reg[c] <= TOL_BUF_RST;
                latl_reg[c] <= TOL_BUF_RST;
                lath_reg[c] <= TOL_BUF_RST[TOL_HI_PINS-1:0];
            end
        end else begin
            for (int c = 0; c < TOL_NUM_CH; c++) begin
                ctrl_reg[c] <= ctrl_next[c];
                mode_reg[c] <= mode_next[c];
                bufl_reg[c] <= bufl_next[c];
                bufh_reg[c] <= bufh_next[c];
                latl_reg[c] <= latl_next[c];
                lath_reg[c] <= lath_next[c];
            end
        end
    end

    // ------------------------------------------------------------------
    // Pins and read data
    // ------------------------------------------------------------------
    // Pins are registered so that they never glitch while the mode or the
    // latch changes; this costs one cycle of delay after each latch update.
    always_comb begin
        rdata_next = '0;
        for (int c = 0; c < TOL_NUM_CH; c++) begin
            pins_next[c] = ctrl_reg[c].channel_enable_bit ? ({lath_reg[c], latl_reg[c]} & mode_reg[c])
                                                          : '0;
            if (reg_rd) begin
                if (reg_addr == TOL_BUFL_ADDR[c] || reg_addr == TOL_BUFH_ADDR[c]) begin
                    rdata_next = {bufh_reg[c], bufl_reg[c]};
                end
                if (reg_addr == TOL_CTRL_ADDR[c]) begin
                    rdata_next = {ctrl_reg[c], 4'h0};
                end
                if (reg_addr == TOL_MODE_ADDR[c]) begin
                    rdata_next = {2'h0, mode_reg[c]};
                end
            end
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            pins_reg  <= '0;
            rdata_reg <= '0;
        end else begin
            pins_reg  <= pins_next;
            rdata_reg <= rdata_next;
        end
    end

    assign channel_output_pins = pins_reg;
    assign reg_rdata           = rdata_reg;

    // ------------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (sys_rst);

    sequence t4_rise_s;
        !timer4_match_trigger ##1 timer4_match_trigger;
    endsequence

    sequence t8_fall_s;
        timer8_match_trigger ##1 !timer8_match_trigger;
    endsequence

    sequence t6_rise_s;
        !timer6_match_trigger ##1 timer6_match_trigger;
    endsequence

    for (genvar g = 0; g < TOL_NUM_CH; g++) begin : g_chk
        logic wl;
        logic wh;
        assign wl = reg_wr && (reg_addr == TOL_BUFL_ADDR[g]);
        assign wh = reg_wr && (reg_addr == TOL_BUFH_ADDR[g]);

        disabled_zero_a: assert property (
            !ctrl_reg[g].channel_enable_bit |=> channel_output_pins[g] == '0)
            else $error("disabled channel pins not zero");

        pin_mask_a: assert property (
            ctrl_reg[g].channel_enable_bit |=>
            channel_output_pins[g] == ($past({lath_reg[g], latl_reg[g]}) & $past(mode_reg[g])))
            else $error("pin does not follow latch and mode");

        trig_copy_a: assert property (
            ctrl_reg[g].channel_enable_bit && fire_reg[g].lo && fire_reg[g].hi |=>
            latl_reg[g] == $past(bufl_reg[g]) && lath_reg[g] == $past(bufh_reg[g][1:0]))
            else $error("trigger did not copy buffers");

        direct_load_a: assert property (
            !ctrl_reg[g].channel_enable_bit && wl && !ctrl_reg[g].width_mode_bit |=>
            latl_reg[g] == $past(reg_wdata[3:0]))
            else $error("disabled write did not load latch");

        no_direct_a: assert property (
            ctrl_reg[g].channel_enable_bit && (wl || wh) && fire_reg[g] == '0 |=>
            $stable(latl_reg[g]) && $stable(lath_reg[g]))
            else $error("enabled write reached latch");

        split_write_a: assert property (
            wl && !ctrl_reg[g].width_mode_bit |=>
            bufl_reg[g] == $past(reg_wdata[3:0]) && $stable(bufh_reg[g]))
            else $error("split write touched wrong nibble");

        wide_write_a: assert property (
            (wl || wh) && ctrl_reg[g].width_mode_bit |=>
            {bufh_reg[g], bufl_reg[g]} == $past(reg_wdata))
            else $error("wide write did not fill both buffers");

        buf_read_a: assert property (
            reg_rd && reg_addr == TOL_BUFH_ADDR[g] |=>
            reg_rdata == {$past(bufh_reg[g]), $past(bufl_reg[g])})
            else $error("buffer read data wrong");

        ctrl_read_a: assert property (
            reg_rd && reg_addr == TOL_CTRL_ADDR[g] |=>
            reg_rdata == {$past(ctrl_reg[g]), 4'h0})
            else $error("control read data wrong");

        mode_read_a: assert property (
            reg_rd && reg_addr == TOL_MODE_ADDR[g] |=>
            reg_rdata == {2'h0, $past(mode_reg[g])})
            else $error("mode read data wrong");
    end

    rise_route_a: assert property (
        t4_rise_s ##0 (ctrl_reg[0] == 4'he) |=> fire_reg[0].hi && fire_reg[0].lo ##1 !fire_reg[0].lo)
        else $error("timer4 rising edge not routed once");

    fall_route_a: assert property (
        t8_fall_s ##0 (ctrl_reg[1] == 4'h8) |=> fire_reg[1].hi ##1 !fire_reg[1].hi)
        else $error("timer8 falling edge not routed once");

    // The short timer 6 pulse also falls next cycle, which rising mode must ignore.
    wide_route_a: assert property (
        t6_rise_s ##0 (ctrl_reg[1] == 4'hf) |=> fire_reg[1].hi && fire_reg[1].lo ##1 !fire_reg[1].hi)
        else $error("timer6 rising edge not routed once");

endmodule : tol_top

// [hdl/tol_pkg.sv]
// Package for the timer-triggered output latch: register map, field layout,
// reset values and the carrier types shared by the design and the bench.
// Assumes a byte-wide register port with 28-bit addresses.
package tol_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int TOL_NUM_CH  = 2;
    localparam int TOL_PINS    = 6;
    localparam int TOL_ADDR_W  = 28;
    localparam int TOL_DATA_W  = 8;
    localparam int TOL_NIB_W   = 4;
    localparam int TOL_HI_PINS = 2;

    // ------------------------------------------------------------------
    // Register map, one entry per channel
    // ------------------------------------------------------------------
    localparam logic [TOL_ADDR_W-1:0] TOL_CTRL_ADDR [TOL_NUM_CH] = '{28'hffff6e5, 28'hffff6f5};
    localparam logic [TOL_ADDR_W-1:0] TOL_BUFL_ADDR [TOL_NUM_CH] = '{28'hffff6e0, 28'hffff6f0};
    localparam logic [TOL_ADDR_W-1:0] TOL_BUFH_ADDR [TOL_NUM_CH] = '{28'hffff6e1, 28'hffff6f1};
    localparam logic [TOL_ADDR_W-1:0] TOL_MODE_ADDR [TOL_NUM_CH] = '{28'hffff6e4, 28'hffff6f4};

    // ------------------------------------------------------------------
    // Control register fields and reset values
    // ------------------------------------------------------------------
    localparam int TOL_EN_BIT    = 7;
    localparam int TOL_EDGE_BIT  = 6;
    localparam int TOL_WIDTH_BIT = 5;
    localparam int TOL_SRC_BIT   = 4;

    localparam logic [TOL_DATA_W-1:0] TOL_CTRL_RST = 8'h00;
    localparam logic [TOL_NIB_W-1:0]  TOL_BUF_RST  = 4'h0;
    localparam logic [TOL_PINS-1:0]   TOL_MODE_RST = 6'h00;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    typedef struct packed {
        logic channel_enable_bit;
        logic trigger_edge_select;
        logic width_mode_bit;
        logic trigger_source_select;
    } tol_ctrl_t;

    typedef struct packed {
        logic hi;
        logic lo;
    } tol_fire_t;

    // Routes three edge-detected timer events to the two latch halves.
    // Event a is the upper split trigger, b the shared middle one, d the
    // alternate source.
    function automatic tol_fire_t tol_route(input tol_ctrl_t c, input logic a, input logic b,
                                            input logic d);
        tol_fire_t f;
        f = '0;
        case ({c.width_mode_bit, c.trigger_source_select})
            2'h0: begin
                f.hi = a;
                f.lo = b;
            end
            2'h1: begin
                f.hi = b;
                f.lo = d;
            end
            2'h2: begin
                f.hi = b;
                f.lo = b;
            end
            default: begin
                f.hi = d;
                f.lo = d;
            end
        endcase
        return f;
    endfunction : tol_route

endpackage : tol_pkg

// [sim/tol_timer_model.sv]
// Timer compare-match source standing in for the six timers feeding the latch.
// Assumes one request at a time, given by the bench right after a clk edge.
`timescale 1ns/100ps

module tol_timer_model
(
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [2:0] idx,
    input  wire logic [3:0] len,
    output logic      [5:0] trig
);
    // ------------------------------------------------------------------
    // Pulse generator
    // ------------------------------------------------------------------
    logic [3:0] left_reg = 4'h0;

    // match pulse of len cycles, one cycle on lines 0 and 3
    // Lines 0 and 3 are the timer 0 and timer 6 outputs, so they never stand longer.
    always @(posedge clk) begin
        if (go) begin
            left_reg <= (idx == 3'h0 || idx == 3'h3) ? 4'h1 : len;
            trig <= 6'h01 << idx;
        end else if (left_reg > 4'h1) begin
            left_reg <= left_reg - 4'h1;
        end else begin
            left_reg <= 4'h0;
            trig <= 6'h00;
        end
    end
endmodule : tol_timer_model

// [sim/timer_triggered_output_latch_test.sv]
// Self-checking bench for the two-channel timer-triggered output latch.
// Assumes the register port answers reads one cycle later and never stalls.
`timescale 1ns/100ps

module timer_triggered_output_latch_test;
    import tol_pkg::*;

    // ------------------------------------------------------------------
    // Signals and bench state
    // ------------------------------------------------------------------
    logic                    clk = 1'b0;
    logic                    sys_rst = 1'b1;
    logic [TOL_ADDR_W-1:0]   reg_addr = '0;
    logic [TOL_DATA_W-1:0]   reg_wdata = '0;
    logic                    reg_wr = 1'b0;
    logic                    reg_rd = 1'b0;
    logic [TOL_DATA_W-1:0]   reg_rdata;
    logic [5:0]              trig;
    logic [1:0][5:0]         channel_output_pins;
    logic                    tgo = 1'b0;
    logic [2:0]              tidx = 3'h0;
    logic                    rd_d = 1'b0;
    logic                    pin_chk = 1'b0;
    logic [11:0]             rd_q[$];
    logic [11:0]             pin_q[$];
    logic [7:0]              bf[2] = '{8'h00, 8'h00};
    logic [5:0]              lat[2] = '{6'h00, 6'h00};
    logic [5:0]              md[2] = '{6'h00, 6'h00};
    logic                    en[2] = '{1'b0, 1'b0};
    logic                    wd[2] = '{1'b0, 1'b0};
    int                      n_fail = 0;
    int                      num_checks = 0;

    always #12.5 clk = ~clk;

    tol_top u_tol_top (.clk(clk), .sys_rst(sys_rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .timer0_match_trigger(trig[0]),
        .timer4_match_trigger(trig[1]), .timer5_match_trigger(trig[2]), .timer6_match_trigger(trig[3]),
        .timer7_match_trigger(trig[4]), .timer8_match_trigger(trig[5]),
        .channel_output_pins(channel_output_pins));

    tol_timer_model u_tol_timer_model (.clk(clk), .go(tgo), .idx(tidx), .len(4'h8), .trig(trig));

    // ------------------------------------------------------------------
    // Checking
    // ------------------------------------------------------------------
    task automatic check(input logic [11:0] seen, input logic [11:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check

    task automatic tally_and_finish();
        if (n_fail == 0 && num_checks > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish

    // Read data stand only in the cycle after the strobe, so they are taken there.
    always @(posedge clk) begin
        if (rd_d) check({4'h0, reg_rdata}, rd_q.pop_front());
        if (pin_chk) check(channel_output_pins, pin_q.pop_front());
        rd_d <= reg_rd;
    end

    function automatic logic [11:0] epins();
        return {en[1] ? (lat[1] & md[1]) : 6'h00, en[0] ? (lat[0] & md[0]) : 6'h00};
    endfunction : epins

    // ------------------------------------------------------------------
    // Drivers
    // ------------------------------------------------------------------
    task automatic wr(input logic [TOL_ADDR_W-1:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(posedge clk);
    endtask : wr

    task automatic rd(input logic [TOL_ADDR_W-1:0] a, input logic [7:0] exp);
        rd_q.push_back({4'h0, exp});
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(posedge clk);
    endtask : rd

    task automatic pins();
        pin_q.push_back(epins());
        pin_chk <= 1'b1;
        @(posedge clk);
        pin_chk <= 1'b0;
        @(posedge clk);
    endtask : pins

    task automatic wb(input int ch, input bit hi, input logic [7:0] x);
        wr(hi ? TOL_BUFH_ADDR[ch] : TOL_BUFL_ADDR[ch], x);
        if (wd[ch]) bf[ch] = x;
        else if (hi) bf[ch][7:4] = x[7:4];
        else bf[ch][3:0] = x[3:0];
        if (!en[ch]) lat[ch] = bf[ch][5:0];
    endtask : wb

    initial begin
        repeat (20000) @(posedge clk);
        n_fail++;
        tally_and_finish();
    end

    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    initial begin : main
        logic [7:0] c, x;
        logic       hf, lf;
        int         k;
        void'($urandom(52557));
        repeat (16) @(posedge clk);
        sys_rst <= 1'b0;
        @(posedge clk);
        for (int ch = 0; ch < 2; ch++) begin
            rd(TOL_CTRL_ADDR[ch], 8'h00);
            rd(TOL_MODE_ADDR[ch], 8'h00);
            rd(TOL_BUFH_ADDR[ch], 8'h00);
            x = 8'($urandom);
            wr(TOL_CTRL_ADDR[ch], x);
            rd(TOL_CTRL_ADDR[ch], x & 8'hf0);
            wr(TOL_CTRL_ADDR[ch], x & 8'h70);
            wr(TOL_CTRL_ADDR[ch], 8'h00);
        end
        rd(28'hffff6e2, 8'h00);
        pins();
        for (int ch = 0; ch < 2; ch++) begin
            for (int cfg = 0; cfg < 8; cfg++) begin
                c = {2'b00, 3'(cfg), 3'h0} << 1;
                wd[ch] = c[TOL_WIDTH_BIT];
                wr(TOL_CTRL_ADDR[ch], c);
                md[ch] = 6'($urandom);
                wr(TOL_MODE_ADDR[ch], {2'b00, md[ch]});
                rd(TOL_MODE_ADDR[ch], {2'b00, md[ch]});
                x = 8'($urandom);
                wb(ch, 1'b0, x);
                rd(TOL_BUFH_ADDR[ch], bf[ch]);
                x = 8'($urandom);
                wb(ch, x[0], x);
                rd(TOL_BUFL_ADDR[ch], bf[ch]);
                pins();
                wr(TOL_CTRL_ADDR[ch], c | 8'h80);
                en[ch] = 1'b1;
                pins();
                // next data loaded before the trigger
                x = 8'($urandom);
                wb(ch, 1'b0, x);
                wb(ch, 1'b1, x);
                pins();
                for (k = 0; k < 3; k++) begin
                    hf = (wd[ch] | c[TOL_SRC_BIT]) ? (k == 1 + (wd[ch] & c[TOL_SRC_BIT])) : (k == 0);
                    lf = c[TOL_SRC_BIT] ? (k == 2) : (k == 1);
                    tidx <= 3'(ch * 3 + 2 - k);
                    tgo <= 1'b1;
                    @(posedge clk);
                    tgo <= 1'b0;
                    repeat (5) @(posedge clk);
                    // mid-pulse the rising edge has landed, the falling not yet
                    if (k != 2) begin
                        if (c[TOL_EDGE_BIT] && hf) lat[ch][5:4] = bf[ch][5:4];
                        if (c[TOL_EDGE_BIT] && lf) lat[ch][3:0] = bf[ch][3:0];
                        pins();
                    end
                    repeat (8) @(posedge clk);
                    if (hf) lat[ch][5:4] = bf[ch][5:4];
                    if (lf) lat[ch][3:0] = bf[ch][3:0];
                    pins();
                end
                wr(TOL_CTRL_ADDR[ch], c);
                en[ch] = 1'b0;
                pins();
            end
        end
        tally_and_finish();
    end
endmodule : timer_triggered_output_latch_test
